// ---- rtl/ofm_pkg.sv ----
// Package for the oscillator fail monitor: timing constants and carrier types.
// Assumes a single 200 MHz system clock.
package ofm_pkg;

    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam int STAB_TIME_NS = 250000;
    localparam int STAB_CYCLES = (STAB_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int POR_TYP_NS = 18000;
    localparam int POR_MAX_NS = 34000;
    localparam int POR_MAX_CYCLES = (POR_MAX_NS * 1000) / CLK_PERIOD_PS;

    // ****************************************
    // Frequency compare
    // ****************************************
    localparam int REF_WINDOW = 16;
    localparam int MAIN_THRESHOLD = 16;
    localparam int CNT_W = 8;

    // ****************************************
    // Reset values
    // ****************************************
    // The block stays passive while its own reset is low
    localparam logic RST_SEL_RC = 1'b0;
    localparam logic RST_RESET_OUT = 1'b0;
    localparam logic RST_RC_ENABLE = 1'b0;
    // Main oscillator counts as failed until a window proves it
    localparam logic RST_MAIN_SLOW = 1'b1;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        OFM_OFF,
        OFM_FAIL,
        OFM_STAB,
        OFM_RUN
    } ofm_state_t;

    typedef struct packed {
        logic sel_rc;
        logic chip_reset;
        logic rc_enable;
        logic port_reset;
    } ofm_ctrl_t;

endpackage : ofm_pkg

// ---- rtl/ofm_edge_cnt.sv ----
// Edge counter: counts rising edges of an oscillator sampled in the system clock.
// Assumes the raw oscillator input is asynchronous to I_CLK.
`timescale 1ns/1ps
module ofm_edge_cnt #(
    parameter int CNT_W = ofm_pkg::CNT_W
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Oscillator and control
    input wire logic osc_in,
    input wire logic clear,
    // Result
    output logic [CNT_W-1:0] count,
    output logic edge_seen
);

    if (CNT_W < 2)
    begin : g_bad_width
        $error("ofm_edge_cnt: counter width must be at least 2");
    end

    logic sync1;
    logic sync2;
    logic sync3;
    logic [CNT_W-1:0] next_count;

    always_comb
    begin
        edge_seen = sync2 & ~sync3;
        next_count = count;
        if (clear)
        begin
            next_count = '0;
        end
        else if (edge_seen && count != {CNT_W{1'b1}})
        begin
            next_count = count + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
            count <= '0;
        end
        else
        begin
            sync1 <= osc_in;
            sync2 <= sync1;
            sync3 <= sync2;
            count <= next_count;
        end
    end

endmodule : ofm_edge_cnt

// ---- rtl/ofm_monitor.sv ----
// Oscillator fail monitor: compares main oscillator against RC reference.
// Assumes both oscillators arrive as slow asynchronous pins sampled by I_CLK.
`timescale 1ns/1ps
module ofm_monitor #(
    parameter int STAB_CYCLES = ofm_pkg::STAB_CYCLES,
    parameter int REF_WINDOW = ofm_pkg::REF_WINDOW,
    parameter int MAIN_THRESHOLD = ofm_pkg::MAIN_THRESHOLD
)
(
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_B,
    // Pins
    input wire logic I_OSC_MONITOR_ENABLE_PIN,
    input wire logic I_HARD_POWERDOWN_PIN_B,
    input wire logic I_MAIN_OSC,
    input wire logic I_RC_OSC,
    // Control outputs
    output logic O_SEL_RC,
    output logic O_CHIP_RESET,
    output logic O_RC_ENABLE,
    output logic O_PORT_RESET
);

    // ****************************************
    // Parameter checks
    // ****************************************
    if (REF_WINDOW < 2 || REF_WINDOW > 255 || MAIN_THRESHOLD < 1 || MAIN_THRESHOLD > 255)
    begin : g_bad_cnt
        $error("ofm_monitor: window or threshold out of range");
    end
    if (STAB_CYCLES < 1)
    begin : g_bad_stab
        $error("ofm_monitor: stabilisation count must be positive");
    end

    localparam int STAB_W = $clog2(STAB_CYCLES + 1);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic en_s1;
    logic en_s2;
    logic pd_s1;
    logic pd_s2;

    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            en_s1 <= 1'b0;
            en_s2 <= 1'b0;
            pd_s1 <= 1'b0;
            pd_s2 <= 1'b0;
        end
        else
        begin
            en_s1 <= I_OSC_MONITOR_ENABLE_PIN;
            en_s2 <= en_s1;
            pd_s1 <= I_HARD_POWERDOWN_PIN_B;
            pd_s2 <= pd_s1;
        end
    end

    // ****************************************
    // Frequency compare
    // ****************************************
    logic [ofm_pkg::CNT_W-1:0] main_count;
    logic [ofm_pkg::CNT_W-1:0] rc_count;
    logic rc_edge;
    logic win_clear;
    logic win_done;
    logic main_slow;
    logic next_main_slow;

    assign win_done = rc_edge && (rc_count == ofm_pkg::CNT_W'(REF_WINDOW - 1));
    assign win_clear = win_done || !en_s2;

    ofm_edge_cnt #(.CNT_W(ofm_pkg::CNT_W)) u_main_cnt (
        .clk(I_CLK),
        .rst_b(I_RST_B),
        .osc_in(I_MAIN_OSC),
        .clear(win_clear),
        .count(main_count),
        .edge_seen()
    );

    ofm_edge_cnt #(.CNT_W(ofm_pkg::CNT_W)) u_rc_cnt (
        .clk(I_CLK),
        .rst_b(I_RST_B),
        .osc_in(I_RC_OSC),
        .clear(win_clear),
        .count(rc_count),
        .edge_seen(rc_edge)
    );

    always_comb
    begin
        next_main_slow = main_slow;
        if (!en_s2 || !pd_s2)
        begin
            next_main_slow = 1'b1;
        end
        else if (win_done)
        begin
            next_main_slow = (main_count < ofm_pkg::CNT_W'(MAIN_THRESHOLD));
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            main_slow <= ofm_pkg::RST_MAIN_SLOW;
        end
        else
        begin
            main_slow <= next_main_slow;
        end
    end

    // ****************************************
    // Supervision state machine
    // ****************************************
    ofm_pkg::ofm_state_t state;
    ofm_pkg::ofm_state_t next_state;
    logic [STAB_W-1:0] stab_cnt;
    logic [STAB_W-1:0] next_stab_cnt;
    ofm_pkg::ofm_ctrl_t ctrl;
    ofm_pkg::ofm_ctrl_t next_ctrl;

    always_comb
    begin
        next_state = state;
        next_stab_cnt = stab_cnt;
        case (state)
            ofm_pkg::OFM_OFF:
            begin
                if (en_s2)
                begin
                    next_state = ofm_pkg::OFM_FAIL;
                end
            end
            ofm_pkg::OFM_FAIL:
            begin
                if (!en_s2)
                begin
                    next_state = ofm_pkg::OFM_OFF;
                end
                else if (!main_slow && pd_s2)
                begin
                    next_state = ofm_pkg::OFM_STAB;
                    next_stab_cnt = STAB_W'(STAB_CYCLES - 1);
                end
            end
            ofm_pkg::OFM_STAB:
            begin
                if (!en_s2)
                begin
                    next_state = ofm_pkg::OFM_OFF;
                end
                else if (main_slow || !pd_s2)
                begin
                    next_state = ofm_pkg::OFM_FAIL;
                end
                else if (stab_cnt == '0)
                begin
                    next_state = ofm_pkg::OFM_RUN;
                end
                else
                begin
                    next_stab_cnt = stab_cnt - 1'b1;
                end
            end
            ofm_pkg::OFM_RUN:
            begin
                if (!en_s2)
                begin
                    next_state = ofm_pkg::OFM_OFF;
                end
                else if (main_slow || !pd_s2)
                begin
                    next_state = ofm_pkg::OFM_FAIL;
                end
            end
            default:
            begin
                next_state = ofm_pkg::OFM_OFF;
            end
        endcase
    end

    always_comb
    begin
        next_ctrl.rc_enable = en_s2;
        next_ctrl.sel_rc = (next_state == ofm_pkg::OFM_FAIL);
        next_ctrl.chip_reset = (next_state == ofm_pkg::OFM_FAIL)
            || (next_state == ofm_pkg::OFM_STAB);
        next_ctrl.port_reset = next_ctrl.chip_reset;
    end

    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            state <= ofm_pkg::OFM_OFF;
            stab_cnt <= '0;
            ctrl.sel_rc <= ofm_pkg::RST_SEL_RC;
            ctrl.chip_reset <= ofm_pkg::RST_RESET_OUT;
            ctrl.rc_enable <= ofm_pkg::RST_RC_ENABLE;
            ctrl.port_reset <= ofm_pkg::RST_RESET_OUT;
        end
        else
        begin
            state <= next_state;
            stab_cnt <= next_stab_cnt;
            ctrl <= next_ctrl;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Reset asserts within a few cycles of enable, far inside the power-on limit
    assign O_SEL_RC = ctrl.sel_rc;
    assign O_CHIP_RESET = ctrl.chip_reset;
    assign O_RC_ENABLE = ctrl.rc_enable;
    assign O_PORT_RESET = ctrl.port_reset;

endmodule : ofm_monitor

// ---- testbench/ofm_monitor_checker.sv ----
// Port checker for the oscillator fail monitor.
// Assumes it is bound to ofm_monitor and sees only its ports.
`timescale 1ns/1ps
module ofm_monitor_checker #(
    parameter int STAB_CYCLES = 20
)
(
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_B,
    // Pins
    input wire logic I_OSC_MONITOR_ENABLE_PIN,
    input wire logic I_HARD_POWERDOWN_PIN_B,
    input wire logic I_MAIN_OSC,
    // Control outputs
    input wire logic O_SEL_RC,
    input wire logic O_CHIP_RESET,
    input wire logic O_RC_ENABLE,
    input wire logic O_PORT_RESET
);
    // ****
    // Hold length and stopped main oscillator counters
    // ****
    logic [15:0] hold;
    logic [9:0] idle;
    logic main_q;
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            hold <= 16'h0000;
            idle <= 10'h000;
            main_q <= 1'b0;
        end
        else
        begin
            hold <= (O_CHIP_RESET && !O_SEL_RC) ? hold + 16'h0001 : 16'h0000;
            idle <= (I_MAIN_OSC != main_q) ? 10'h000 : idle + 10'(idle != 10'h3FF);
            main_q <= I_MAIN_OSC;
        end
    end
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);
    a_sel_needs_reset: assert property (O_SEL_RC |-> O_CHIP_RESET)
        else $error("RC clock selected outside reset");
    a_port_follows_reset: assert property (O_PORT_RESET == O_CHIP_RESET)
        else $error("port reset differs from chip reset");
    a_hold_length: assert property ($fell(O_CHIP_RESET) && O_RC_ENABLE |->
        hold >= STAB_CYCLES - 1 && hold <= STAB_CYCLES + 1)
        else $error("final reset phase has wrong length");
    a_off_no_effect: assert property (!I_OSC_MONITOR_ENABLE_PIN [*6] |->
        !O_RC_ENABLE && !O_SEL_RC && !O_CHIP_RESET)
        else $error("disabled monitor still acts");
    a_rc_enable_on: assert property (I_OSC_MONITOR_ENABLE_PIN [*6] |-> O_RC_ENABLE)
        else $error("RC oscillator not enabled");
    a_powerdown_fail: assert property ((I_OSC_MONITOR_ENABLE_PIN && !I_HARD_POWERDOWN_PIN_B) [*6]
        |-> O_SEL_RC && O_CHIP_RESET)
        else $error("power-down not held in RC reset");
    a_power_on_reset: assert property ($rose(I_OSC_MONITOR_ENABLE_PIN) ##1
        I_OSC_MONITOR_ENABLE_PIN [*6] |-> O_CHIP_RESET && O_SEL_RC)
        else $error("no RC reset after enable");
    a_stopped_main_fail: assert property (idle == 10'h3FF && O_RC_ENABLE
        |-> O_SEL_RC && O_CHIP_RESET)
        else $error("stopped main oscillator not caught");
endmodule : ofm_monitor_checker

bind ofm_monitor ofm_monitor_checker #(.STAB_CYCLES(STAB_CYCLES)) u_chk (.I_CLK(I_CLK),
    .I_RST_B(I_RST_B), .I_OSC_MONITOR_ENABLE_PIN(I_OSC_MONITOR_ENABLE_PIN),
    .I_HARD_POWERDOWN_PIN_B(I_HARD_POWERDOWN_PIN_B), .I_MAIN_OSC(I_MAIN_OSC),
    .O_SEL_RC(O_SEL_RC), .O_CHIP_RESET(O_CHIP_RESET), .O_RC_ENABLE(O_RC_ENABLE),
    .O_PORT_RESET(O_PORT_RESET));

// ---- testbench/ofm_osc_model.sv ----
// Model of the main crystal and the auxiliary RC oscillator.
// Assumes the bench clock; waves are whole cycles of it.
`timescale 1ns/1ps
module ofm_osc_model
(
    // Clock
    input wire logic i_clk,
    // Control
    input wire logic i_rc_en,
    input wire logic i_main_run,
    input wire logic [7:0] i_main_half,
    // Oscillators
    output logic o_main_osc,
    output logic o_rc_osc
);
    localparam logic [7:0] RC_HALF = 8'h0A;
    logic [7:0] mc = 8'h00;
    logic [7:0] rc = 8'h00;
    initial o_main_osc = 1'b0;
    initial o_rc_osc = 1'b0;
    // A stopped oscillator holds its level; a disabled RC stands low
    always @(posedge i_clk)
    begin
        mc <= (mc + 8'h01 >= i_main_half) ? 8'h00 : mc + 8'h01;
        if (i_main_run && mc + 8'h01 >= i_main_half)
            o_main_osc <= ~o_main_osc;
        rc <= (rc + 8'h01 >= RC_HALF) ? 8'h00 : rc + 8'h01;
        if (!i_rc_en)
            o_rc_osc <= 1'b0;
        else if (rc + 8'h01 >= RC_HALF)
            o_rc_osc <= ~o_rc_osc;
    end
endmodule : ofm_osc_model

// ---- testbench/ofm_monitor_test.sv ----
// Self-checking bench for the oscillator fail monitor.
// Assumes the oscillator model runs the RC at a 20-cycle period.
`timescale 1ns/1ps
module ofm_monitor_test;
    localparam int STAB = 20;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic en_pin = 1'b0;
    logic pd_b = 1'b1;
    logic main_run = 1'b0;
    logic [7:0] main_half = 8'h03;
    logic main_osc, rc_osc, sel_rc, chip_rst, rc_en, port_rst;
    logic [7:0] h;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    always #2.5 clk = ~clk;
    ofm_monitor #(.STAB_CYCLES(STAB)) DUT (.I_CLK(clk), .I_RST_B(rst_b),
        .I_OSC_MONITOR_ENABLE_PIN(en_pin), .I_HARD_POWERDOWN_PIN_B(pd_b),
        .I_MAIN_OSC(main_osc), .I_RC_OSC(rc_osc), .O_SEL_RC(sel_rc),
        .O_CHIP_RESET(chip_rst), .O_RC_ENABLE(rc_en), .O_PORT_RESET(port_rst));
    ofm_osc_model u_osc (.i_clk(clk), .i_rc_en(rc_en), .i_main_run(main_run),
        .i_main_half(main_half), .o_main_osc(main_osc), .o_rc_osc(rc_osc));
    task conclude;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude
    task check_bit(input string name, input logic exp, input logic got);
        total_checks++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %b seen %b", name, exp, got);
            bad_count++;
        end
    endtask : check_bit
    // Main slower than the RC reference counts as a failure
    function automatic logic exp_fail(input logic [7:0] half);
        return half > 8'h0A;
    endfunction : exp_fail
    task settle_check(input int n, input logic fail, input logic ren);
        repeat (n) @(negedge clk);
        check_bit("O_SEL_RC", fail, sel_rc);
        check_bit("O_CHIP_RESET", fail, chip_rst);
        check_bit("O_PORT_RESET", fail, port_rst);
        check_bit("O_RC_ENABLE", ren, rc_en);
        @(posedge clk);
    endtask : settle_check
    task measure_hold;
        int n;
        n = 0;
        // Look only at settled outputs, never in the launching edge's time step
        @(negedge clk);
        while (sel_rc !== 1'b0 && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (chip_rst !== 1'b0 && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
        check_bit("hold length", 1'b1, logic'(n >= STAB - 1 && n <= STAB + 1));
        @(posedge clk);
    endtask : measure_hold
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            bad_count++;
            conclude();
        end
    end
    initial
    begin
        void'($urandom(32'h31a9b1d0));
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        settle_check(8, 1'b0, 1'b0);
        en_pin <= 1'b1;
        settle_check(7, 1'b1, 1'b1);
        main_run <= 1'b1;
        measure_hold();
        settle_check(2, 1'b0, 1'b1);
        main_half <= 8'h1E;
        settle_check(1200, 1'b1, 1'b1);
        main_half <= 8'h04;
        settle_check(1200, 1'b0, 1'b1);
        pd_b <= 1'b0;
        settle_check(8, 1'b1, 1'b1);
        pd_b <= 1'b1;
        measure_hold();
        // Stopped main oscillator must be caught as a failure
        main_run <= 1'b0;
        settle_check(1200, 1'b1, 1'b1);
        main_run <= 1'b1;
        measure_hold();
        en_pin <= 1'b0;
        settle_check(8, 1'b0, 1'b0);
        en_pin <= 1'b1;
        repeat (8)
        begin
            h = ($urandom & 1) ? 8'($urandom_range(7, 3)) : 8'($urandom_range(40, 14));
            main_half <= h;
            settle_check(1200, exp_fail(h), 1'b1);
        end
        conclude();
    end
endmodule : ofm_monitor_test
